// [verilog/fsc_pkg.sv]
// Constants, register map and state layout of the fan speed clock configuration block.
// Assumes a single 10 MHz system clock and an Avalon-MM master reaching the registers.
// Summary of operation
// - Channel one's speed clock comes from its source-select bit 0, its doubling bit and bit 7 of duty register one.
// - Channel two's speed clock comes from its source-select bit 1, its doubling bit and bit 7 of duty register two.
// - Bit 2 clear leaves channel one's chosen speed alone, bit 2 set doubles it.
// - Bit 3 clear leaves channel two's chosen speed alone, bit 3 set doubles it.
// - Bits 5:4 divide the clock counted by channel one's tachometer, code 00 meaning divide by one.
// - Bits 7:6 divide channel two's tachometer clock by 1, 2, 4 or 8 for codes 00 to 11.
// - Power-on reset loads the configuration register with 0x50.
// - Each duty register holds its channel's clock-select bit at bit 7.
// - Each tachometer counts divided clocks per fan pulse and latches the final 8-bit count for reading.
package fsc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [6:0] IDX_DUTY_A = 7'h56;
  localparam logic [6:0] IDX_DUTY_B = 7'h57;
  localparam logic [6:0] IDX_CONFIG = 7'h58;
  localparam logic [6:0] IDX_TACH_A = 7'h59;
  localparam logic [6:0] IDX_TACH_B = 7'h5a;

  // Reset values.
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h50;
  localparam logic [7:0] RST_TACH = 8'h00;

  // Field positions.
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_DBL_LSB = 2;
  localparam int CFG_DIV_A_LSB = 4;
  localparam int CFG_DIV_B_LSB = 6;
  localparam int DUTY_FORCE_BIT = 0;
  localparam int DUTY_LVL_LSB = 1;
  localparam int DUTY_CSEL_BIT = 7;

  // Speed tick periods in system cycles, indexed by {clock select, source select}.
  localparam logic [15:0] SPD_DIV_00 = 16'h0100;
  localparam logic [15:0] SPD_DIV_01 = 16'h0080;
  localparam logic [15:0] SPD_DIV_10 = 16'h0040;
  localparam logic [15:0] SPD_DIV_11 = 16'h0020;

  // Base tachometer counting tick in system cycles, before the per-channel divisor.
  localparam logic [15:0] TACH_TICK_CYC = 16'h0064;

  localparam int NCH = 2;

  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic [7:0] cfg;
    logic [NCH-1:0][7:0] duty;
    logic [NCH-1:0][15:0] spd_cnt;
    logic [NCH-1:0][5:0] pwm_cnt;
    logic [NCH-1:0] speed;
    logic [15:0] tick_cnt;
    logic [NCH-1:0][2:0] tsync;
    logic [NCH-1:0] tlevel;
    logic [NCH-1:0][2:0] tscale;
    logic [NCH-1:0][7:0] tcount;
    logic [NCH-1:0][7:0] tlatch;
  } fsc_state_s;

endpackage

// [verilog/fsc_top.sv]
// Fan speed output generation, tachometer counting and their registers on Avalon-MM.
// Assumes tachometer pins are asynchronous and the bus master holds each request until
// it sees waitrequest low.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
module fsc_top
  import fsc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Avalon-MM slave.
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Fan pins.
  output logic speed_out_a,
  output logic speed_out_b,
  input wire logic tach_in_a,
  input wire logic tach_in_b
);

  fsc_state_s st_ff;
  fsc_state_s nxt_st;

  logic [6:0] idx;
  logic [NCH-1:0] tach_pin;
  logic req_taken;
  logic wr_commit;

  assign idx = avs_address[8:2];
  assign tach_pin = {tach_in_b, tach_in_a};

  // A request is taken on the edge where it meets waitrequest high; a write commits on
  // the following edge, the one at which the master samples waitrequest low.
  assign req_taken = (avs_read || avs_write) && st_ff.wait_req;
  assign wr_commit = avs_write && !st_ff.wait_req && avs_byteenable[0];

  // Speed tick period for a channel; the doubling bit halves the period.
  function automatic logic [15:0] spd_period(input logic csel, input logic src,
                                             input logic dbl);
    logic [15:0] p;
    case ({csel, src})
      2'b00: p = SPD_DIV_00;
      2'b01: p = SPD_DIV_01;
      2'b10: p = SPD_DIV_10;
      default: p = SPD_DIV_11;
    endcase
    if (dbl) begin
      p = p >> 1;
    end
    return p;
  endfunction

  // Number of base ticks per counted tachometer clock, minus one.
  function automatic logic [2:0] tach_limit(input logic [1:0] code);
    logic [2:0] l;
    case (code)
      2'b00: l = 3'h0;
      2'b01: l = 3'h1;
      2'b10: l = 3'h3;
      default: l = 3'h7;
    endcase
    return l;
  endfunction

  // Readback of one register index. The data sits in the low lane; the upper lanes and
  // unmapped indices read as zero so software can probe the map safely.
  function automatic logic [31:0] reg_read(input logic [6:0] i, input fsc_state_s s);
    logic [7:0] b;
    case (i)
      IDX_DUTY_A: b = s.duty[0];
      IDX_DUTY_B: b = s.duty[1];
      IDX_CONFIG: b = s.cfg;
      IDX_TACH_A: b = s.tlatch[0];
      IDX_TACH_B: b = s.tlatch[1];
      default: b = 8'h00;
    endcase
    return {24'h000000, b};
  endfunction

  // Write of the low byte lane into the register state. The tachometer registers are
  // read-only and unmapped indices are ignored, so both leave the state as it was.
  function automatic fsc_state_s reg_write(input fsc_state_s s, input logic [6:0] i,
                                           input logic [7:0] b);
    fsc_state_s n;
    n = s;
    case (i)
      IDX_DUTY_A: n.duty[0] = b;
      IDX_DUTY_B: n.duty[1] = b;
      IDX_CONFIG: n.cfg = b;
      default: n = s;
    endcase
    return n;
  endfunction

  // Pulse-width level of one channel: the force bit holds the pin high, otherwise the
  // pin is high while the 64-step pattern is below the six-bit duty level.
  function automatic logic speed_level(input logic [7:0] duty, input logic [5:0] step);
    logic lvl;
    if (duty[DUTY_FORCE_BIT]) begin
      lvl = 1'b1;
    end else begin
      lvl = step < duty[DUTY_LVL_LSB +: 6];
    end
    return lvl;
  endfunction

  // A level change of a tachometer pin is accepted only once the last two synchroniser
  // stages agree, so a single-cycle glitch or a metastable first stage never counts.
  function automatic logic tach_settled(input logic [2:0] sync, input logic level);
    return (sync[2] == sync[1]) && (sync[2] != level);
  endfunction

  // Divisor code of one channel's tachometer clock. Both fields use the same code
  // table, so one limit function serves the two channels.
  function automatic logic [1:0] tach_code(input logic [7:0] cfg, input int ch);
    logic [1:0] code;
    if (ch == 0) begin
      code = cfg[CFG_DIV_A_LSB +: 2];
    end else begin
      code = cfg[CFG_DIV_B_LSB +: 2];
    end
    return code;
  endfunction

  always_comb begin
    logic [15:0] period;
    logic [1:0] div_code;
    logic base_tick;
    logic edge_seen;
    period = 16'h0000;
    div_code = 2'b00;
    base_tick = 1'b0;
    edge_seen = 1'b0;
    nxt_st = st_ff;

    // One wait cycle per access: the request is taken at one edge, waitrequest is low
    // through the next cycle with read data already loaded, and at the following edge
    // the master takes the data and a write commits. Waitrequest then rises again, so a
    // request held past that edge would be taken a second time.
    nxt_st.wait_req = !req_taken;
    if (avs_read && st_ff.wait_req) begin
      nxt_st.rdata = reg_read(idx, st_ff);
    end
    if (wr_commit) begin
      nxt_st = reg_write(nxt_st, idx, avs_writedata[7:0]);
    end

    // Shared base tick for the tachometers. One divider serves both channels, so a
    // channel's count is uncertain by one tick: a pulse edge may fall at any phase of
    // the shared tick.
    if (st_ff.tick_cnt >= TACH_TICK_CYC - 16'h0001) begin
      nxt_st.tick_cnt = 16'h0000;
      base_tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 16'h0001;
    end

    for (int ch = 0; ch < NCH; ch++) begin
      // Speed output: a 64-step pulse width pattern advanced by the selected speed tick.
      period = spd_period(st_ff.duty[ch][DUTY_CSEL_BIT], st_ff.cfg[CFG_SRC_LSB + ch],
                          st_ff.cfg[CFG_DBL_LSB + ch]);
      if (st_ff.spd_cnt[ch] >= period - 16'h0001) begin
        nxt_st.spd_cnt[ch] = 16'h0000;
        nxt_st.pwm_cnt[ch] = st_ff.pwm_cnt[ch] + 6'h01;
      end else begin
        nxt_st.spd_cnt[ch] = st_ff.spd_cnt[ch] + 16'h0001;
      end
      nxt_st.speed[ch] = speed_level(st_ff.duty[ch], st_ff.pwm_cnt[ch]);

      // Tachometer pin: three flops, a change is accepted once the last two agree.
      nxt_st.tsync[ch] = {st_ff.tsync[ch][1:0], tach_pin[ch]};
      if (tach_settled(st_ff.tsync[ch], st_ff.tlevel[ch])) begin
        nxt_st.tlevel[ch] = st_ff.tsync[ch][2];
        edge_seen = st_ff.tsync[ch][2];
      end else begin
        edge_seen = 1'b0;
      end

      div_code = tach_code(st_ff.cfg, ch);
      if (edge_seen) begin
        // A rising pulse edge closes the previous pulse's count and starts a new one.
        nxt_st.tlatch[ch] = st_ff.tcount[ch];
        nxt_st.tcount[ch] = 8'h00;
        nxt_st.tscale[ch] = 3'h0;
      end else if (base_tick) begin
        if (st_ff.tscale[ch] >= tach_limit(div_code)) begin
          nxt_st.tscale[ch] = 3'h0;
          // Saturate so a pulse longer than 255 counts reads as the slowest speed rather than wrapping.
          if (st_ff.tcount[ch] != 8'hff) begin
            nxt_st.tcount[ch] = st_ff.tcount[ch] + 8'h01;
          end
        end else begin
          nxt_st.tscale[ch] = st_ff.tscale[ch] + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
      // Waitrequest leaves reset high: the bus only ever answers a request it has taken.
      st_ff.wait_req <= 1'b1;
      st_ff.cfg <= RST_CONFIG;
      st_ff.duty <= {RST_DUTY, RST_DUTY};
      st_ff.tlatch <= {RST_TACH, RST_TACH};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_req;
  assign speed_out_a = st_ff.speed[0];
  assign speed_out_b = st_ff.speed[1];

endmodule

// [tb/fsc_top_asserts.sv]
// Checker of the bus handshake and output reset levels of fsc_top.
// Assumes it is bound to fsc_top and that the master holds each request.
`timescale 1ns/1ns
module fsc_top_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic speed_out_a,
  input wire logic speed_out_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("request not answered");
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest fell without request");
  rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without read");
  rdata_width_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  spd_a_reset_a: assert property ($rose(arst_n) |-> !speed_out_a)
    else $error("speed a high after reset");
  spd_b_reset_a: assert property ($rose(arst_n) |-> !speed_out_b)
    else $error("speed b high after reset");
endmodule
bind fsc_top fsc_top_asserts chk (.clk_sys, .arst_n, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdata, .speed_out_a, .speed_out_b);

// [tb/fsc_fan.sv]
// Fan model: a tachometer pulse train with a fixed half period in clocks.
// Assumes clk_sys is the only clock; the fan spins whatever its speed input.
`timescale 1ns/1ns
module fsc_fan #(parameter int HALF = 1000) (
  input wire logic clk_sys,
  input wire logic speed,
  output logic tach
);
  int cnt = 0;
  initial tach = 1'b0;
  always @(posedge clk_sys) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) tach <= ~tach;
  end
endmodule

// [tb/fan_speed_clock_config_tb.sv]
// Self-checking bench of fsc_top: register model, tachometer and speed period checks.
// Assumes two fsc_fan models drive the tachometer pins.
`timescale 1ns/1ns
module fan_speed_clock_config_tb;
  logic clk_sys = 0, arst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic speed_out_a, speed_out_b, tach_in_a, tach_in_b;
  logic [8:0] avs_address = 9'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, d;
  int n_mismatch = 0, n_tests = 0, seed = 61690, regs[int], p;
  fsc_top DUT (.clk_sys, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .speed_out_a, .speed_out_b,
    .tach_in_a, .tach_in_b);
  fsc_fan #(.HALF(1000)) fan_a (.clk_sys, .speed(speed_out_a), .tach(tach_in_a));
  fsc_fan #(.HALF(700)) fan_b (.clk_sys, .speed(speed_out_b), .tach(tach_in_b));
  initial forever #50 clk_sys = ~clk_sys;
  // The four passes need about 50000 cycles; the limit leaves room.
  initial begin
    #7500000;
    n_mismatch++;
    conclude();
  end
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(string s, logic [31:0] e, logic [31:0] v);
    n_tests++;
    if (e !== v) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", s, e, v);
    end
  endtask
  task automatic bus(logic w, logic [6:0] i, logic [31:0] wd, logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= {i, 2'b00};
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(int i, logic [31:0] wd, logic [3:0] be);
    bus(1'b1, i[6:0], wd, be);
    if (be[0] && regs.exists(i)) regs[i] = wd[7:0];
  endtask
  task automatic rd(int i);
    bus(1'b0, i[6:0], 32'h0, 4'hf);
    check("register", regs.exists(i) ? regs[i] : 0, q);
  endtask
  // The tick phase against the fan edge makes the count uncertain by one.
  function automatic logic [31:0] near(int e);
    return (q + 1 >= e && q <= e + 1) ? e : q;
  endfunction
  initial begin
    regs[8'h56] = 0;
    regs[8'h57] = 0;
    regs[8'h58] = 8'h50;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 8'h55; i < 8'h5c; i++) rd(i);
    repeat (16) begin
      d = $random(seed);
      wr(8'h55 + d[9:8], d, {3'b0, d[12]});
      rd(8'h55 + d[9:8]);
    end
    wr(8'h56, 32'hc0, 4'hf);
    wr(8'h57, 32'hc0, 4'hf);
    for (int c = 0; c < 4; c++) begin
      wr(8'h58, {c[1:0], c[1:0], c[1], c[0], c[0], 1'b1}, 4'hf);
      wr(8'h59, 32'hff, 4'hf);
      repeat (4500) @(posedge clk_sys);
      bus(1'b0, 7'h59, 32'h0, 4'hf);
      check("tach_a", 2000 / (100 << c), near(2000 / (100 << c)));
      bus(1'b0, 7'h5a, 32'h0, 4'hf);
      check("tach_b", 1400 / (100 << c), near(1400 / (100 << c)));
      @(posedge speed_out_a);
      p = $time;
      @(posedge speed_out_a);
      check("period_a", 2048 >> c[0], ($time - p) / 100);
      @(posedge speed_out_b);
      p = $time;
      @(posedge speed_out_b);
      check("period_b", (4096 >> c[0]) >> c[1], ($time - p) / 100);
    end
    conclude();
  end
endmodule
